// >>> bench/operating_mode_register_bench.sv
// Testbench for the operating mode register: reset values, write permissions and map control
`default_nettype none
module operating_mode_register_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i;
  logic        sys_rst_i;
  logic [2:0]  strap_mode_i;
  logic        secured_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [2:0]  op_sel_field_o;
  logic        internal_visibility_enable_o;
  logic        port_k_emulation_o;
  logic        port_e_emulation_o;
  logic        mode_reg_mapped_o;
  logic        port_k_regs_mapped_o;
  logic        port_e_regs_mapped_o;
  logic        external_echo_o;
  int          num_errors;
  int          comparisons;
  logic [31:0] rdata;
  logic        rerr;
  logic        echo;
  logic [7:0]  rst_tab [8];

  operating_mode_register uut (
    .clk_i                        (clk_i),
    .sys_rst_i                    (sys_rst_i),
    .strap_mode_i                 (strap_mode_i),
    .secured_i                    (secured_i),
    .psel_i                       (psel_i),
    .penable_i                    (penable_i),
    .pwrite_i                     (pwrite_i),
    .paddr_i                      (paddr_i),
    .pwdata_i                     (pwdata_i),
    .prdata_o                     (prdata_o),
    .pready_o                     (pready_o),
    .pslverr_o                    (pslverr_o),
    .op_sel_field_o               (op_sel_field_o),
    .internal_visibility_enable_o (internal_visibility_enable_o),
    .port_k_emulation_o           (port_k_emulation_o),
    .port_e_emulation_o           (port_e_emulation_o),
    .mode_reg_mapped_o            (mode_reg_mapped_o),
    .port_k_regs_mapped_o         (port_k_regs_mapped_o),
    .port_e_regs_mapped_o         (port_e_regs_mapped_o),
    .external_echo_o              (external_echo_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz
  always #25 clk_i = ~clk_i;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= addr;
    pwdata_i  <= {24'h00_0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) begin
      num_errors++;
      summarize();
    end
    rdata = prdata_o;
    rerr  = pslverr_o;
    echo  = external_echo_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clk_i);
  endtask

  // Reset into a strapped mode, then wait out the first cycle after release
  task automatic start(input logic [2:0] m, input logic sec);
    @(posedge clk_i);
    sys_rst_i    <= 1'b1;
    strap_mode_i <= m;
    secured_i    <= sec;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Outputs, map control and readback against an expected register value
  task automatic expect_state(input logic [7:0] v);
    logic single;
    single = !v[5] && v[7:5] != 3'h6;
    check(op_sel_field_o, v[7:5]);
    check(internal_visibility_enable_o, v[3]);
    check(port_k_emulation_o, v[1]);
    check(port_e_emulation_o, v[0]);
    check(mode_reg_mapped_o, single);
    check(port_k_regs_mapped_o, single || (v[5] && !v[1]));
    check(port_e_regs_mapped_o, single || !v[0]);
    apb(1'b0, 12'h000, 8'h00);
    check(rerr, !single);
    check(echo, !single);
    if (single) check(rdata, {24'h00_0000, v});
  endtask

  // Verdict
  task automatic summarize();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    strap_mode_i = 3'h0;
    secured_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    num_errors = 0;
    comparisons = 0;
    rst_tab = '{8'h00, 8'h2B, 8'h48, 8'h6B, 8'h80, 8'hA0, 8'hC0, 8'hE0};
    // Every strapped mode: reset value, map state, locked modes refuse writes
    for (int i = 0; i < 8; i++) begin
      start(3'(i), 1'b0);
      expect_state(rst_tab[i]);
      apb(1'b0, 12'h004, 8'h00);
      check(rdata, 32'(i));
      if (i % 2 == 1 || i == 6) begin
        apb(1'b1, 12'h000, 8'h00);
        expect_state(rst_tab[i]);
      end
    end
    // Special single-chip: peripheral refused, free writes, then one more from normal
    start(3'h0, 1'b0);
    apb(1'b1, 12'h000, 8'hC0);
    expect_state(8'h00);
    apb(1'b1, 12'h000, 8'h5F);
    expect_state(8'h4B);
    apb(1'b1, 12'h000, 8'hC8);
    expect_state(8'h48);
    apb(1'b1, 12'h000, 8'h80);
    expect_state(8'h80);
    apb(1'b1, 12'h000, 8'hE0);
    expect_state(8'hE0);
    // Normal single-chip: mode, visibility and port K once; port E never
    start(3'h4, 1'b0);
    apb(1'b1, 12'h000, 8'h0B);
    expect_state(8'h8A);
    apb(1'b1, 12'h000, 8'hA0);
    expect_state(8'h8A);
    // Normal single-chip: a cleared top bit in the write is ignored
    start(3'h4, 1'b0);
    apb(1'b1, 12'h000, 8'h20);
    expect_state(8'hA0);
    // Secured: mode field frozen, other bits still follow their permissions
    start(3'h0, 1'b1);
    apb(1'b1, 12'h000, 8'h4B);
    expect_state(8'h0B);
    apb(1'b0, 12'h008, 8'h00);
    check(rerr, 1'b1);
    summarize();
  end

  // Watchdog against a hung transfer
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire

// >>> rtl/op_mode_pkg.sv
// Package: offsets, field positions, reset values and mode codes of the operating mode register
`default_nettype none
package op_mode_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] MODE_OFFSET   = 12'h000;
  localparam logic [11:0] STRAP_OFFSET  = 12'h004;  // Read-only view of the strapped mode caught during reset
  // Field positions
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int INTERNAL_VISIBILITY_ENABLE_BIT = 3;
  localparam int EMK_BIT  = 1;
  localparam int EME_BIT  = 0;
  // Writable bit mask (bits 4 and 2 unimplemented)
  localparam logic [7:0] IMPL_MASK = 8'hEB;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'h0,
    MODE_EMUL_NARROW    = 3'h1,
    MODE_SPECIAL_TEST   = 3'h2,
    MODE_EMUL_WIDE      = 3'h3,
    MODE_NORMAL_SINGLE  = 3'h4,
    MODE_NORMAL_NARROW  = 3'h5,
    MODE_PERIPHERAL     = 3'h6,
    MODE_NORMAL_WIDE    = 3'h7
  } op_mode_t;
  // Reset values per entered mode
  localparam logic [7:0] RST_SPECIAL_SINGLE = 8'h00;
  localparam logic [7:0] RST_EMUL_NARROW    = 8'h2B;
  localparam logic [7:0] RST_SPECIAL_TEST   = 8'h48;
  localparam logic [7:0] RST_EMUL_WIDE      = 8'h6B;
  localparam logic [7:0] RST_NORMAL_SINGLE  = 8'h80;
  localparam logic [7:0] RST_NORMAL_NARROW  = 8'hA0;
  localparam logic [7:0] RST_PERIPHERAL     = 8'hC0;
  localparam logic [7:0] RST_NORMAL_WIDE    = 8'hE0;
endpackage
`default_nettype wire

// >>> rtl/operating_mode_register.sv
// Operating mode register with per-mode write permission and memory map control
`default_nettype none
module operating_mode_register (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  strap_mode_i,
  input  wire logic        secured_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [2:0]       op_sel_field_o,
  output logic             internal_visibility_enable_o,
  output logic             port_k_emulation_o,
  output logic             port_e_emulation_o,
  output logic             mode_reg_mapped_o,
  output logic             port_k_regs_mapped_o,
  output logic             port_e_regs_mapped_o,
  output logic             external_echo_o
);
  logic [2:0] op_sel_field_r;
  logic [2:0] strap_r;
  logic       rst_load_r;
  logic       sel_once_used_r;
  logic       sel_wr_done_r;
  logic       apb_access;
  logic       mode_hit;
  logic       strap_hit;
  logic       wr_mode;
  logic [2:0] new_sel;
  logic [2:0] sel_target;
  logic       is_special;
  logic       is_emul;
  logic       is_normal;
  logic       is_single;
  logic       is_periph;
  logic       is_expanded;
  logic       sel_wr_ok;
  logic [7:0] reg_view;
  logic [7:0] rst_val;
  logic [31:0] prdata_r;
  logic       pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Strap caught while reset is held, used at release
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strap_r <= strap_mode_i;
    end
  end

  // One-cycle load pulse after reset release
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rst_load_r <= 1'b1;
    end else begin
      rst_load_r <= 1'b0;
    end
  end

  // Reset value table per entered mode
  always_comb begin
    unique case (op_mode_pkg::op_mode_t'(strap_r))
      op_mode_pkg::MODE_SPECIAL_SINGLE: rst_val = op_mode_pkg::RST_SPECIAL_SINGLE;
      op_mode_pkg::MODE_EMUL_NARROW:    rst_val = op_mode_pkg::RST_EMUL_NARROW;
      op_mode_pkg::MODE_SPECIAL_TEST:   rst_val = op_mode_pkg::RST_SPECIAL_TEST;
      op_mode_pkg::MODE_EMUL_WIDE:      rst_val = op_mode_pkg::RST_EMUL_WIDE;
      op_mode_pkg::MODE_NORMAL_SINGLE:  rst_val = op_mode_pkg::RST_NORMAL_SINGLE;
      op_mode_pkg::MODE_NORMAL_NARROW:  rst_val = op_mode_pkg::RST_NORMAL_NARROW;
      op_mode_pkg::MODE_PERIPHERAL:     rst_val = op_mode_pkg::RST_PERIPHERAL;
      op_mode_pkg::MODE_NORMAL_WIDE:    rst_val = op_mode_pkg::RST_NORMAL_WIDE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode class decode from the current field
  assign is_periph   = (op_sel_field_r == 3'(op_mode_pkg::MODE_PERIPHERAL));
  assign is_emul     = !op_sel_field_r[2] && op_sel_field_r[0];
  assign is_special  = !op_sel_field_r[2] && !op_sel_field_r[0];
  assign is_normal   = op_sel_field_r[2] && !is_periph;
  assign is_single   = !op_sel_field_r[0] && !is_periph;
  assign is_expanded = op_sel_field_r[0];

  // Map control: off chip map in expanded and peripheral modes
  assign mode_reg_mapped_o = is_single;
  assign external_echo_o   = psel_i && !mode_reg_mapped_o;
  assign port_k_regs_mapped_o = is_single || (is_expanded && !port_k_emulation_o);
  assign port_e_regs_mapped_o = is_single || !port_e_emulation_o;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states
  assign apb_access = psel_i && penable_i;
  assign mode_hit   = (paddr_i == op_mode_pkg::MODE_OFFSET) && mode_reg_mapped_o;
  assign strap_hit  = (paddr_i == op_mode_pkg::STRAP_OFFSET);
  assign wr_mode    = apb_access && pwrite_i && mode_hit && !rst_load_r;
  assign new_sel    = pwdata_i[op_mode_pkg::SEL_MSB:op_mode_pkg::SEL_LSB];
  assign pready_o   = 1'b1;

  // Field written: the top bit is not writable from normal single-chip
  assign sel_target = is_normal ? {1'b1, new_sel[1:0]} : new_sel;

  // Mode select write permission
  always_comb begin
    sel_wr_ok = 1'b0;
    if (secured_i) begin
      sel_wr_ok = 1'b0;
    end else if (op_sel_field_r[0]) begin
      sel_wr_ok = 1'b0;
    end else if (is_special) begin
      sel_wr_ok = !sel_wr_done_r && (new_sel != 3'(op_mode_pkg::MODE_PERIPHERAL));
    end else if (is_normal) begin
      sel_wr_ok = !sel_once_used_r && new_sel[0];
    end
  end

  // Mode field, applied on the edge ending the write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_sel_field_r <= 3'h0;
    end else if (rst_load_r) begin
      op_sel_field_r <= rst_val[op_mode_pkg::SEL_MSB:op_mode_pkg::SEL_LSB];
    end else if (wr_mode && sel_wr_ok) begin
      op_sel_field_r <= sel_target;
    end
  end

  // Write-once bookkeeping for the mode field
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || rst_load_r) begin
      sel_once_used_r <= 1'b0;
      sel_wr_done_r   <= 1'b0;
    end else if (wr_mode && !secured_i) begin
      if (is_normal) begin
        sel_once_used_r <= 1'b1;
      end
      if (is_special && sel_wr_ok && new_sel[0]) begin
        sel_wr_done_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Visibility and port emulation bits
  write_once_bit u_internal_visibility_enable (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_val_i (rst_val[op_mode_pkg::INTERNAL_VISIBILITY_ENABLE_BIT]),
    .wr_i      (wr_mode),
    .wdata_i   (pwdata_i[op_mode_pkg::INTERNAL_VISIBILITY_ENABLE_BIT]),
    .anytime_i (is_special),
    .once_i    (is_normal),
    .q_o       (internal_visibility_enable_o)
  );

  write_once_bit u_emk (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_val_i (rst_val[op_mode_pkg::EMK_BIT]),
    .wr_i      (wr_mode),
    .wdata_i   (pwdata_i[op_mode_pkg::EMK_BIT]),
    .anytime_i (is_special),
    .once_i    (is_normal),
    .q_o       (port_k_emulation_o)
  );

  write_once_bit u_eme (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_val_i (rst_val[op_mode_pkg::EME_BIT]),
    .wr_i      (wr_mode),
    .wdata_i   (pwdata_i[op_mode_pkg::EME_BIT]),
    .anytime_i (is_special),
    .once_i    (1'b0),
    .q_o       (port_e_emulation_o)
  );

  assign op_sel_field_o = op_sel_field_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read view with unimplemented bits at zero
  always_comb begin
    reg_view = 8'h00;
    reg_view[op_mode_pkg::SEL_MSB:op_mode_pkg::SEL_LSB] = op_sel_field_r;
    reg_view[op_mode_pkg::INTERNAL_VISIBILITY_ENABLE_BIT] = internal_visibility_enable_o;
    reg_view[op_mode_pkg::EMK_BIT]  = port_k_emulation_o;
    reg_view[op_mode_pkg::EME_BIT]  = port_e_emulation_o;
    reg_view = reg_view & op_mode_pkg::IMPL_MASK;
  end

  // Read data and error register on setup phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      if (!pwrite_i && mode_hit) begin
        prdata_r <= {24'h00_0000, reg_view};
      end else if (!pwrite_i && strap_hit) begin
        prdata_r <= {29'h0000_0000, strap_r};
      end else if (!mode_hit && !strap_hit) begin
        pslverr_r <= 1'b1;
      end
    end
  end

  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r && apb_access;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_secure_block;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_mode && secured_i) |=> $stable(op_sel_field_r);
  endproperty
  a_secure_block: assert property (p_secure_block) else $error("Secured mode write took effect");

  property p_emul_lock;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!rst_load_r && op_sel_field_r[0]) |=> (op_sel_field_r == $past(op_sel_field_r));
  endproperty
  a_emul_lock: assert property (p_emul_lock) else $error("Mode changed with bit zero set");

  property p_no_periph_entry;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!rst_load_r && op_sel_field_r != 3'h6) |=> (op_sel_field_r != 3'h6);
  endproperty
  a_no_periph_entry: assert property (p_no_periph_entry) else $error("Entered peripheral mode");

  property p_write_applies;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_mode && sel_wr_ok) |=> (op_sel_field_r == $past(sel_target));
  endproperty
  a_write_applies: assert property (p_write_applies) else $error("Allowed write not applied");

  // Normal single-chip left by a write in the cycle before
  sequence s_leave_normal_single;
    (!rst_load_r && op_sel_field_r == 3'h4 && !secured_i) ##1 (op_sel_field_r != 3'h4);
  endsequence

  property p_normal_single_target;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_leave_normal_single |-> (op_sel_field_r == 3'h5 || op_sel_field_r == 3'h7);
  endproperty
  a_normal_single_target: assert property (p_normal_single_target) else $error("Bad normal target");

  property p_reset_value;
    @(posedge clk_i) (rst_load_r && !sys_rst_i) |=> (op_sel_field_r == $past(strap_r));
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Reset mode not loaded");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      (apb_access && !pwrite_i && mode_hit) |-> (prdata_o[4] == 1'b0 && prdata_o[2] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read nonzero");

  property p_map_off;
    @(posedge clk_i) disable iff (sys_rst_i)
      (apb_access && paddr_i == op_mode_pkg::MODE_OFFSET && !is_single) |-> pslverr_o;
  endproperty
  a_map_off: assert property (p_map_off) else $error("Unmapped register access not flagged");

  property p_port_k_map;
    @(posedge clk_i) disable iff (sys_rst_i)
      is_periph |-> !port_k_regs_mapped_o;
  endproperty
  a_port_k_map: assert property (p_port_k_map) else $error("Port K mapped in peripheral");

  property p_eme_frozen;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!rst_load_r && !is_special) |=> $stable(port_e_emulation_o);
  endproperty
  a_eme_frozen: assert property (p_eme_frozen) else $error("Port E bit written outside special");

  property p_single_maps;
    @(posedge clk_i) disable iff (sys_rst_i)
      is_single |-> (port_k_regs_mapped_o && port_e_regs_mapped_o);
  endproperty
  a_single_maps: assert property (p_single_maps) else $error("Port unmapped in single-chip");

  property p_port_k_unmap;
    @(posedge clk_i) disable iff (sys_rst_i)
      (is_expanded && port_k_emulation_o) |-> !port_k_regs_mapped_o;
  endproperty
  a_port_k_unmap: assert property (p_port_k_unmap) else $error("Port K stays mapped");

  property p_port_e_unmap;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!is_single && port_e_emulation_o) |-> !port_e_regs_mapped_o;
  endproperty
  a_port_e_unmap: assert property (p_port_e_unmap) else $error("Port E stays mapped");

  property p_emul_bits_frozen;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!rst_load_r && is_emul) |=> $stable({internal_visibility_enable_o, port_k_emulation_o});
  endproperty
  a_emul_bits_frozen: assert property (p_emul_bits_frozen) else $error("Emulation bit written");

  property p_normal_top_kept;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_mode && op_sel_field_r == 3'h4) |=> op_sel_field_r[2];
  endproperty
  a_normal_top_kept: assert property (p_normal_top_kept) else $error("Top mode bit cleared");

  property p_normal_once;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_mode && is_normal && sel_once_used_r) |=> $stable(op_sel_field_r);
  endproperty
  a_normal_once: assert property (p_normal_once) else $error("Second normal mode write taken");

  property p_periph_stays;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!rst_load_r && is_periph) |=> is_periph;
  endproperty
  a_periph_stays: assert property (p_periph_stays) else $error("Peripheral mode left");
endmodule
`default_nettype wire

// >>> rtl/write_once_bit.sv
// Single control bit with write-anytime, write-once or write-never permission
`default_nettype none
module write_once_bit (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_val_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  input  wire logic anytime_i,
  input  wire logic once_i,
  output logic      q_o
);
  logic used_r;
  logic rst_load_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bit value; reset value comes from the entered mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_o <= 1'b0;
    end else if (rst_load_r) begin
      q_o <= rst_val_i;
    end else if (wr_i && (anytime_i || (once_i && !used_r))) begin
      q_o <= wdata_i;
    end
  end

  // Reset value loaded on the first edge after release
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rst_load_r <= 1'b1;
    end else begin
      rst_load_r <= 1'b0;
    end
  end

  // Write-once is spent by the first write attempt
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      used_r <= 1'b0;
    end else if (wr_i && once_i && !rst_load_r) begin
      used_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire
